// ### hw/dsg_top.v
// deep-sleep port clock gating and software reset control over apb
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
`include "dsg_consts.vh"
module dsg_top
(
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// system state from the clock controller
	input  wire        auto_clock_gating,
	input  wire [1:0]  power_mode,
	input  wire [31:0] device_capabilities_1,
	// port access monitor: a bus access aimed at port n
	input  wire        port_access,
	input  wire [2:0]  port_index,
	// outputs
	output reg  [7:0]  port_clk_en,
	output reg         port_bus_fault,
	output reg         pwm_reset,
	output reg         adc_reset,
	output reg         hibernation_reset_bit,
	output reg         watchdog_reset_bit
);
	// state
	reg  [31:0] software_reset_ctl_0;  // reset request bits
	reg  [7:0]  run_clock_gate_2;      // run-mode gate word
	reg  [7:0]  sleep_clock_gate_2;    // sleep-mode gate word
	wire [7:0]  deep_sleep_clock_gate_2; // deep-sleep gate word
	wire [7:0]  gate_now;              // gate for the current mode
	wire        setup;                 // setup phase of a transfer
	wire        wr;                    // write in the completing access phase
	reg  [31:0] next_rdata;            // read mux
	reg         next_err;              // unmapped address

	// address decode helper used by write and read paths
	function hit;
		input [11:0] a;
		input [11:0] ofs;
		begin
			hit = (a[11:2] == ofs[11:2]);
		end
	endfunction

	// answer in the access phase one cycle after setup, no wait states
	assign setup = psel & ~penable;
	// a write lands only at the edge where the master sees pready high,
	// so a master that stretched its setup never commits a half-made write
	assign wr    = psel & penable & pready & pwrite;

	// deep-sleep gate word, cleared by reset
	dsg_reg8 u_deep
	(
		.pclk    (pclk),
		.presetn (presetn),
		.we      (wr & hit(paddr, `DSG_OFS_DSGATE)), // RQ7
		.wdata   (pwdata[7:0]),                       // RQ1 RQ6
		.q       (deep_sleep_clock_gate_2)            // RQ3
	);

	// choose the gate word that applies in the current mode
	dsg_gate_sel u_sel
	(
		.run_gate          (run_clock_gate_2),
		.sleep_gate        (sleep_clock_gate_2),
		.deep_gate         (deep_sleep_clock_gate_2),
		.power_mode        (power_mode),
		.auto_clock_gating (auto_clock_gating),
		.gate              (gate_now)
	);

	// writable registers; writes land at the completing access edge
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			software_reset_ctl_0 <= `DSG_SRST_RESET; // RQ13
			run_clock_gate_2     <= 8'h00;
			sleep_clock_gate_2   <= 8'h00;
		end
		else if (wr)
		begin
			// mask by capabilities and implemented bits
			if (hit(paddr, `DSG_OFS_SRST)) // RQ7
				software_reset_ctl_0 <= pwdata & device_capabilities_1 & `DSG_SRST_MASK; // RQ8 RQ6
			if (hit(paddr, `DSG_OFS_RUNGATE))
				run_clock_gate_2 <= pwdata[7:0];
			if (hit(paddr, `DSG_OFS_SLPGATE))
				sleep_clock_gate_2 <= pwdata[7:0];
		end
	end

	// read mux; reserved bits return zero
	always @*
	begin
		next_rdata = 32'h00000000;
		next_err   = 1'b0;
		if (hit(paddr, `DSG_OFS_SRST))
			next_rdata = software_reset_ctl_0; // RQ6
		else if (hit(paddr, `DSG_OFS_DSGATE))
			next_rdata = {24'h000000, deep_sleep_clock_gate_2}; // RQ6
		else if (hit(paddr, `DSG_OFS_RUNGATE))
			next_rdata = {24'h000000, run_clock_gate_2};
		else if (hit(paddr, `DSG_OFS_SLPGATE))
			next_rdata = {24'h000000, sleep_clock_gate_2};
		else if (hit(paddr, `DSG_OFS_MODE))
			next_rdata = {29'h00000000, auto_clock_gating, power_mode};
		else
			next_err = 1'b1; // unmapped: error answer
	end

	// apb answer registers: pready high for exactly the access cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup & next_err;
			prdata  <= (setup & ~pwrite) ? next_rdata : 32'h00000000;
		end
	end

	// outputs: clock enables, fault pulse and unit resets
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			port_clk_en           <= 8'h00; // RQ3
			port_bus_fault        <= 1'b0;
			pwm_reset             <= 1'b0;
			adc_reset             <= 1'b0;
			hibernation_reset_bit <= 1'b0;
			watchdog_reset_bit    <= 1'b0;
		end
		else
		begin
			port_clk_en    <= gate_now; // RQ1 RQ4 RQ5
			// fault is judged on the enable actually applied to the port
			port_bus_fault <= port_access & ~port_clk_en[port_index]; // RQ2
			pwm_reset             <= software_reset_ctl_0[`DSG_BIT_PWM];  // RQ9 RQ14
			adc_reset             <= software_reset_ctl_0[`DSG_BIT_ADC];  // RQ10 RQ14
			hibernation_reset_bit <= software_reset_ctl_0[`DSG_BIT_HIB];  // RQ11 RQ14
			watchdog_reset_bit    <= software_reset_ctl_0[`DSG_BIT_WDOG]; // RQ12 RQ14
		end
	end
endmodule

// ### shared/dsg_consts.vh
// constants for the deep-sleep clock gate and software reset block
// How it works
// [RQ1] gate bits 7:0 clock ports A..H in deep-sleep
// [RQ2] access to a gated-off unit raises bus fault
// [RQ3] all gate bits reset cleared
// [RQ4] deep-sleep gate applies only in deep-sleep
// [RQ5] sleep gating needs auto clock gating bit
// [RQ6] reserved bits read zero, read-only
// [RQ7] gate at 0x128, reset at 0x040
// [RQ8] reset writes masked by capabilities register
// [RQ9] bit 20 resets pulse-width modulator
// [RQ10] bit 16 resets converter module 0
// [RQ11] bit 6 resets hibernation module
// [RQ12] bit 3 resets watchdog unit
// [RQ13] reset register comes up all zeros
// [RQ14] set bit holds unit in reset
`ifndef DSG_CONSTS_VH
`define DSG_CONSTS_VH
`define DSG_OFS_SRST       12'h040
`define DSG_OFS_DSGATE     12'h128
`define DSG_OFS_RUNGATE    12'h108
`define DSG_OFS_SLPGATE    12'h118
`define DSG_OFS_MODE       12'h400
`define DSG_GATE_MASK      32'h000000FF
`define DSG_SRST_MASK      32'h00110048
`define DSG_BIT_PWM        20
`define DSG_BIT_ADC        16
`define DSG_BIT_HIB        6
`define DSG_BIT_WDOG       3
`define DSG_GATE_RESET     8'h00
`define DSG_SRST_RESET     32'h00000000
`define DSG_MODE_RUN       2'h0
`define DSG_MODE_SLEEP     2'h1
`define DSG_MODE_DEEP      2'h2
`endif

// ### hw/dsg_reg8.v
// eight-bit software register with asynchronous clear
`timescale 1ns/1ns
module dsg_reg8
(
	// clock and reset
	input  wire       pclk,
	input  wire       presetn,
	// write side
	input  wire       we,
	input  wire [7:0] wdata,
	// stored value
	output reg  [7:0] q
);
	// store on write strobe, clear on reset
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= 8'h00;
		else if (we)
			q <= wdata;
	end
endmodule

// ### hw/dsg_gate_sel.v
// picks the active clock gate word from the power mode
`timescale 1ns/1ns
`include "dsg_consts.vh"
module dsg_gate_sel
(
	// gate words for each mode
	input  wire [7:0] run_gate,
	input  wire [7:0] sleep_gate,
	input  wire [7:0] deep_gate,
	// mode control
	input  wire [1:0] power_mode,
	input  wire       auto_clock_gating,
	// selected enables
	output reg  [7:0] gate
);
	// run gating unless auto gating lets the sleep words take over
	always @*
	begin
		gate = run_gate;
		if (auto_clock_gating) // RQ5
		begin
			if (power_mode == `DSG_MODE_DEEP)
				gate = deep_gate; // RQ4
			else if (power_mode == `DSG_MODE_SLEEP)
				gate = sleep_gate;
		end
	end
endmodule

// ### testbench/dsg_chk.sv
// checker for the deep-sleep gate and software reset block
`timescale 1ns/1ns
module dsg_chk (
	input logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input logic [11:0] paddr,
	input logic [31:0] pwdata, prdata, device_capabilities_1,
	input logic        auto_clock_gating, port_access, port_bus_fault,
	input logic [1:0]  power_mode,
	input logic [2:0]  port_index,
	input logic [7:0]  port_clk_en,
	input logic        pwm_reset, adc_reset, hibernation_reset_bit, watchdog_reset_bit
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// a write lands at the access edge that completes the transfer
	wire       wr = psel && penable && pready && pwrite;
	wire       deep = power_mode == 2'h2 && auto_clock_gating;
	wire [7:0] wd = pwdata[7:0];
	// reset bits that a write may set, and the unit reset outputs
	wire [3:0] m = {pwdata[20], pwdata[16], pwdata[6], pwdata[3]} &
		{device_capabilities_1[20], device_capabilities_1[16],
		device_capabilities_1[6], device_capabilities_1[3]};
	wire [3:0] u = {pwm_reset, adc_reset, hibernation_reset_bit, watchdog_reset_bit};
	a_ready_next: assert property (psel && !penable |=> pready) else $error("no ready");
	a_gate_deep: assert property (wr && paddr == 12'h128 && deep ##1 deep
		|=> port_clk_en == $past(wd, 2)) else $error("deep gate not applied");
	a_gate_held: assert property (wr && paddr != 12'h108 && !auto_clock_gating
		##1 !auto_clock_gating
		|=> $stable(port_clk_en)) else $error("gate moved without auto gating");
	a_fault_gated: assert property (port_access && !port_clk_en[port_index]
		|=> port_bus_fault) else $error("missing bus fault");
	a_fault_clocked: assert property (port_access && port_clk_en[port_index]
		|=> !port_bus_fault) else $error("bus fault on clocked port");
	a_srst_mask: assert property (wr && paddr == 12'h040
		|=> ##1 u == $past(m, 2)) else $error("unit resets wrong");
	a_rsvd_zero: assert property (pready && !pwrite && paddr == 12'h128
		|-> prdata[31:8] == 24'h0) else $error("reserved bits not zero");
	a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("bad error");
	c_deep: cover property (wr && paddr == 12'h128 && deep);
	c_fault: cover property (port_bus_fault);
	c_err: cover property (pslverr);
endmodule
bind dsg_top dsg_chk u_chk (.*);

// ### testbench/dsg_host.sv
// apb host model standing in for the processor core
`timescale 1ns/1ns
module dsg_host (
	input  logic        pclk, pready,
	output logic        psel, penable, pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata
);
	initial {psel, penable, pwrite, paddr, pwdata} = '0;
	// one transfer, held until pready is seen high at an edge
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		repeat ($urandom % 2) @(posedge pclk);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		{psel, penable} <= 2'b00;
	endtask
endmodule

// ### testbench/tb.sv
// self-checking bench for the gate and soft reset block
`timescale 1ns/1ns
module tb;
	logic        pclk, presetn, pwrite, psel, penable, pready, pslverr, port_bus_fault;
	logic        auto_clock_gating = 0, port_access = 0;
	logic [1:0]  power_mode = 0;
	logic [2:0]  port_index = 0;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, device_capabilities_1 = 0, d, cap;
	logic [7:0]  port_clk_en;
	logic        pwm_reset, adc_reset, hibernation_reset_bit, watchdog_reset_bit;
	logic [32:0] q[$];
	int          miscompares = 0, checked = 0;
	wire  [3:0]  units = {pwm_reset, adc_reset, hibernation_reset_bit, watchdog_reset_bit};
	dsg_top u_dut (.*);
	dsg_host u_h (.*);
	initial
	begin
		pclk = 0;
		forever #10 pclk = ~pclk;
	end
	task chk(string n, logic [32:0] s, logic [32:0] e);
		checked++;
		if (s !== e)
		begin
			miscompares++;
			$display("ERROR %s exp %h seen %h", n, e, s);
		end
	endtask
	// note the expected answer, then issue the read
	task rd(logic [11:0] a, logic [32:0] e);
		q.push_back(e);
		u_h.xfer(0, a, 0);
	endtask
	task report_and_stop;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// each read answer is matched with the oldest note
	always @(posedge pclk)
		if (pready === 1'b1 && !pwrite) chk("prdata", {pslverr, prdata}, q.pop_front());
	initial
	begin
		#20000 miscompares++;
		report_and_stop;
	end
	initial
	begin
		presetn = 0;
		d = $urandom(32'h6d56);
		repeat (6) @(posedge pclk);
		presetn <= 1;
		rd(12'h128, 0);
		rd(12'h040, 0);
		rd(12'h200, 33'h100000000);
		$display("test reset done");
		d = $urandom;
		u_h.xfer(1, 12'h128, d);
		rd(12'h128, d & 32'hFF);
		for (int m = 0; m < 8; m++)
		begin
			{auto_clock_gating, power_mode} <= m[2:0];
			repeat (2) @(posedge pclk);
			chk("gate", port_clk_en, m == 6 ? d[7:0] : 8'h0);
		end
		{auto_clock_gating, power_mode} <= 3'h6;
		d = $urandom;
		u_h.xfer(1, 12'h128, d);
		repeat (2) @(posedge pclk);
		chk("deep gate", port_clk_en, d[7:0]);
		port_access <= 1;
		for (int i = 0; i < 8; i++)
		begin
			port_index <= i[2:0];
			repeat (2) @(posedge pclk);
			chk("fault", port_bus_fault, !d[i]);
		end
		port_access <= 0;
		$display("test gate done");
		cap = $urandom | 32'h00100008;
		device_capabilities_1 <= cap;
		u_h.xfer(1, 12'h040, '1);
		repeat (2) @(posedge pclk);
		chk("resets", units, {cap[20], cap[16], cap[6], cap[3]});
		rd(12'h040, cap & 32'h00110048);
		u_h.xfer(1, 12'h040, 0);
		repeat (2) @(posedge pclk);
		chk("release", units, 0);
		$display("test resets done");
		// a mid-run reset must clear the gate word again
		u_h.xfer(1, 12'h128, 32'h000000FF);
		presetn <= 0;
		@(posedge pclk);
		presetn <= 1;
		chk("reset gate", port_clk_en, 0);
		rd(12'h128, 0);
		$display("test mid reset done");
		report_and_stop;
	end
endmodule
